// >>> rtl/brls_scheduler.sv
// link-layer tx/rx scheduler for the basic unacknowledged rf modes
`timescale 1ns/1ps
module brls_scheduler #(
  parameter int SLOT_CYC   = brls_pkg::SLOT_CYCLES,
  parameter int BYTE_CYC   = brls_pkg::BYTE_CYCLES,
  parameter int LISTEN_CYC = brls_pkg::LISTEN_CYCLES
) (
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  // configuration
  input  wire brls_pkg::brls_cfg_type     cfg_in,
  input  wire logic [15:0]                seed_in,
  // host transmit buffer
  input  wire logic [brls_pkg::CNT_W-1:0] tx_level_in,
  // radio transmit side
  output brls_pkg::brls_pkt_type          tx_pkt_out,
  output logic                            tx_start_out,
  input  wire logic                       tx_done_in,
  // radio receive side
  input  wire logic                       rx_valid_in,
  input  wire brls_pkg::brls_hdr_type     rx_hdr_in,
  output logic                            rx_enable_out,
  // host output and channel control
  output logic                            deliver_out,
  output logic                            drop_out,
  output logic                            retune_out,
  output logic                            listen_out,
  // status
  output logic                            tx_holdoff_out,
  output logic                            cfg_err_out
);

  localparam int CW = brls_pkg::CNT_W;

  typedef enum logic [1:0] {TX_IDLE, TX_BUSY, TX_GAP} brls_tx_state_type;

  function automatic logic [7:0] brls_rand_below(input logic [15:0] r,
                                                 input logic [7:0]  n);
    logic [15:0] m;
    m = (n == 8'h00) ? 16'h0000 : r % {8'h00, n};
    return m[7:0];
  endfunction : brls_rand_below

  function automatic logic [7:0] brls_max8(input logic [7:0] a,
                                           input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction : brls_max8

  ////////////////////////////////////////////////////////////////////////////
  // random source and slot divider

  logic [15:0] lfsr_r, lfsr_nxt;
  logic        seeded_r;
  logic [31:0] slot_cnt_r, slot_cnt_nxt;
  logic        slot_tick;
  logic        slot_restart;

  // seed taken on the first clock after reset release, never under reset
  always_comb begin
    lfsr_nxt = {lfsr_r[14:0], ^(lfsr_r & brls_pkg::LFSR_TAPS)};
    if (!seeded_r) begin
      lfsr_nxt = (seed_in == 16'h0000) ? brls_pkg::LFSR_RESET : seed_in;
    end
    slot_cnt_nxt = (slot_restart || slot_tick) ? 32'h0 : slot_cnt_r + 32'h1;
  end

  assign slot_tick = (slot_cnt_r == 32'(SLOT_CYC - 1));

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lfsr_r     <= brls_pkg::LFSR_RESET;
      seeded_r   <= 1'b0;
      slot_cnt_r <= 32'h0;
    end else begin
      lfsr_r     <= lfsr_nxt;
      seeded_r   <= 1'b1;
      slot_cnt_r <= slot_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path

  logic                   rxq_v_r;
  brls_pkg::brls_hdr_type rxq_r;
  logic                   tag_hit;
  logic                   is_global, is_local, is_rep_mode, accept;
  logic                   deliver_r, deliver_nxt, drop_r, drop_nxt;
  logic                   rep_pend_r, rep_pend_nxt;
  brls_pkg::brls_hdr_type rep_hdr_r, rep_hdr_nxt;
  logic [7:0]             rx_slots_nxt;
  logic [CW-1:0]          hold_cyc_r, hold_cyc_nxt;
  logic [7:0]             pend_slots_r, pend_slots_nxt;
  logic [31:0]            listen_r, listen_nxt;
  logic                   retune_r, retune_nxt;
  logic                   rep_taken;
  logic                   rx_en;

  assign is_rep_mode = (cfg_in.mode == brls_pkg::MODE_REPEAT) ||
                       (cfg_in.mode == brls_pkg::MODE_DEST);
  assign is_global   = (rxq_r.dest_address == brls_pkg::GLOBAL_ADDR);
  assign is_local    = ((rxq_r.dest_address ^ cfg_in.source_address) &
                        cfg_in.address_mask) == '0;
  assign accept      = rxq_v_r && !(is_rep_mode && tag_hit);

  brls_tag_record brls_tag_record_i (
    .ref_clk_in  (ref_clk_in),
    .rst_n_in    (rst_n_in),
    .look_in     (rx_valid_in && rx_en),
    .look_tag_in (rx_hdr_in.packet_tag),
    .hit_out     (tag_hit),
    .ins_in      (accept && is_rep_mode),
    .ins_tag_in  (rxq_r.packet_tag)
  );

  always_comb begin
    deliver_nxt    = 1'b0;
    drop_nxt       = 1'b0;
    rep_pend_nxt   = rep_pend_r && !rep_taken;
    rep_hdr_nxt    = rep_hdr_r;
    rx_slots_nxt   = 8'h00;
    hold_cyc_nxt   = (hold_cyc_r != '0) ? hold_cyc_r - 1'b1 : hold_cyc_r;
    pend_slots_nxt = (hold_cyc_r == '0) ? 8'h00 : pend_slots_r;
    listen_nxt     = (listen_r != 32'h0) ? listen_r - 32'h1 : listen_r;
    retune_nxt     = 1'b0;
    if (accept) begin
      // global or own address goes to the host, others are dropped
      deliver_nxt = is_global || is_local;
      drop_nxt    = !(is_global || is_local);
      // repeat global and foreign packets once, destinations never
      if (cfg_in.mode == brls_pkg::MODE_REPEAT &&
          (is_global || !is_local)) begin
        rep_pend_nxt = 1'b1;
        rep_hdr_nxt  = rxq_r;
      end
      if (rxq_r.multi) begin
        hold_cyc_nxt   = rxq_r.remain_cyc;
        pend_slots_nxt = brls_rand_below(lfsr_r, cfg_in.delay_slot_count);
      end else if (rxq_r.stream_end) begin
        rx_slots_nxt = brls_rand_below(lfsr_r, cfg_in.delay_slot_count);
      end
      if (rxq_r.follow_on) begin
        retune_nxt = 1'b1;
        listen_nxt = 32'(LISTEN_CYC);
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rxq_v_r      <= 1'b0;
      rxq_r        <= '0;
      deliver_r    <= 1'b0;
      drop_r       <= 1'b0;
      rep_pend_r   <= 1'b0;
      rep_hdr_r    <= '0;
      hold_cyc_r   <= '0;
      pend_slots_r <= 8'h00;
      listen_r     <= 32'h0;
      retune_r     <= 1'b0;
    end else begin
      rxq_v_r      <= rx_valid_in && rx_en;
      rxq_r        <= rx_hdr_in;
      deliver_r    <= deliver_nxt;
      drop_r       <= drop_nxt;
      rep_pend_r   <= rep_pend_nxt;
      rep_hdr_r    <= rep_hdr_nxt;
      hold_cyc_r   <= hold_cyc_nxt;
      pend_slots_r <= pend_slots_nxt;
      listen_r     <= listen_nxt;
      retune_r     <= retune_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit scheduler

  brls_tx_state_type      st_r, st_nxt;
  brls_pkg::brls_pkt_type pkt_r, pkt_nxt;
  logic                   start_r, start_nxt;
  logic [CW-1:0]          sent_r, sent_nxt;
  logic [3:0]             copies_r, copies_nxt;
  logic                   in_event_r, in_event_nxt;
  logic [7:0]             seq_r, seq_nxt;
  logic [7:0]             hold_slots_r, hold_slots_nxt;
  logic [31:0]            idle_r, idle_nxt;
  logic [CW-1:0]          prev_lvl_r;
  logic                   is_multi, bad_cfg, blocked, gate_ok;
  logic [CW-1:0]          room, len_pick;
  logic [7:0]             tx_slots;

  assign is_multi = (cfg_in.mode == brls_pkg::MODE_MULTI);
  assign bad_cfg  = (cfg_in.mode == brls_pkg::MODE_STREAM &&
                     cfg_in.retry_count != 4'h0) ||
                    (is_multi && cfg_in.extra_transmit_count == 4'h0);
  // responses wait while the network carries earlier traffic
  assign blocked  = (hold_slots_r != 8'h00) || (hold_cyc_r != '0) ||
                    (pend_slots_r != 8'h00) || (listen_r != 32'h0) ||
                    rep_pend_r;
  assign gate_ok  = (tx_level_in != '0) &&
                    ((tx_level_in >= cfg_in.packetization_threshold) ||
                     (idle_r >= 32'(cfg_in.packetization_timeout) *
                                32'(BYTE_CYC)));
  assign room     = cfg_in.streaming_limit - sent_r;
  always_comb begin
    len_pick = tx_level_in;
    if (len_pick > cfg_in.max_packet_size) begin
      len_pick = cfg_in.max_packet_size;
    end
    if (len_pick > room) begin
      len_pick = room;
    end
  end

  assign rep_taken = (st_r == TX_IDLE) && rep_pend_r && !in_event_r;
  assign rx_en     = (st_r == TX_IDLE) || !is_multi || pkt_r.repeat_copy;
  assign tx_slots  = (cfg_in.delay_slot_count == 8'h00) ? 8'h01 :
                     brls_rand_below(lfsr_r, cfg_in.delay_slot_count) + 8'h01;

  always_comb begin
    st_nxt         = st_r;
    pkt_nxt        = pkt_r;
    start_nxt      = 1'b0;
    sent_nxt       = sent_r;
    copies_nxt     = copies_r;
    in_event_nxt   = in_event_r;
    seq_nxt        = seq_r;
    slot_restart   = 1'b0;
    hold_slots_nxt = hold_slots_r;
    if (slot_tick && hold_slots_r != 8'h00) begin
      hold_slots_nxt = hold_slots_r - 8'h01;
    end
    if (rx_slots_nxt != 8'h00 && rx_slots_nxt > hold_slots_r) begin
      hold_slots_nxt = rx_slots_nxt;
      slot_restart   = 1'b1;
    end
    if (hold_cyc_r == 16'h0001 && pend_slots_r != 8'h00) begin
      hold_slots_nxt = brls_max8(hold_slots_nxt, pend_slots_r);
      slot_restart   = 1'b1;
    end
    case (st_r)
      TX_IDLE: begin
        if (rep_taken) begin
          pkt_nxt    = '{rep_hdr_r.len, rep_hdr_r.dest_address,
                         rep_hdr_r.packet_tag, 1'b1, 1'b1};
          copies_nxt = 4'h0;
          start_nxt  = 1'b1;
          st_nxt     = TX_BUSY;
        end else if (!bad_cfg && !cfg_err_out && len_pick != '0 &&
                     (in_event_r || (!blocked && gate_ok))) begin
          seq_nxt      = seq_r + 8'h01;
          pkt_nxt      = '{len_pick, cfg_in.dest_address,
                           {cfg_in.source_address[7:0], seq_r},
                           is_multi || !in_event_r, 1'b0};
          copies_nxt   = is_multi ? cfg_in.extra_transmit_count : 4'h0;
          in_event_nxt = 1'b1;
          start_nxt    = 1'b1;
          st_nxt       = TX_BUSY;
        end
      end
      TX_BUSY: begin
        if (tx_done_in) begin
          st_nxt = TX_GAP;
          if (copies_r != 4'h0) begin
            copies_nxt = copies_r - 4'h1;
            start_nxt  = 1'b1;
            st_nxt     = TX_BUSY;
          end else if (!pkt_r.repeat_copy) begin
            sent_nxt = sent_r + pkt_r.len;
          end
        end
      end
      TX_GAP: begin
        // host has taken the bytes; decide whether the event goes on
        st_nxt = TX_IDLE;
        if (pkt_r.repeat_copy) begin
          st_nxt = TX_IDLE;
        end else if (sent_r >= cfg_in.streaming_limit) begin
          hold_slots_nxt = tx_slots;
          slot_restart   = 1'b1;
          in_event_nxt   = 1'b0;
          sent_nxt       = '0;
        end else if (tx_level_in == '0) begin
          if (!is_multi && cfg_in.delay_slot_count != 8'h00) begin
            hold_slots_nxt = cfg_in.delay_slot_count;
            slot_restart   = 1'b1;
          end
          in_event_nxt = 1'b0;
          sent_nxt     = '0;
        end
      end
      default: begin
        st_nxt = TX_IDLE;
      end
    endcase
  end

  always_comb begin
    idle_nxt = (tx_level_in != prev_lvl_r || st_r != TX_IDLE) ? 32'h0 :
               (idle_r == 32'hFFFF_FFFF) ? idle_r : idle_r + 32'h1;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r         <= TX_IDLE;
      pkt_r        <= '0;
      start_r      <= 1'b0;
      sent_r       <= '0;
      copies_r     <= 4'h0;
      in_event_r   <= 1'b0;
      seq_r        <= 8'h00;
      hold_slots_r <= 8'h00;
      idle_r       <= 32'h0;
      prev_lvl_r   <= '0;
      cfg_err_out  <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      pkt_r        <= pkt_nxt;
      start_r      <= start_nxt;
      sent_r       <= sent_nxt;
      copies_r     <= copies_nxt;
      in_event_r   <= in_event_nxt;
      seq_r        <= seq_nxt;
      hold_slots_r <= hold_slots_nxt;
      idle_r       <= idle_nxt;
      prev_lvl_r   <= tx_level_in;
      cfg_err_out  <= bad_cfg;
    end
  end

  assign tx_pkt_out     = pkt_r;
  assign tx_start_out   = start_r;
  assign rx_enable_out  = rx_en;
  assign deliver_out    = deliver_r;
  assign drop_out       = drop_r;
  assign retune_out     = retune_r;
  assign listen_out     = (listen_r != 32'h0);
  assign tx_holdoff_out = blocked;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_global_deliver: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) accept && is_global |=> deliver_out && !drop_out)
    else $error("global packet not delivered");
  a_foreign_drop: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) accept && !is_global && !is_local |=> drop_out)
    else $error("foreign packet not dropped");
  a_seen_ignored: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) rxq_v_r && is_rep_mode && tag_hit
    |=> !deliver_out && !drop_out)
    else $error("seen tag was not ignored");
  a_size_cap: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) tx_start_out && !tx_pkt_out.repeat_copy
    |-> tx_pkt_out.len <= cfg_in.max_packet_size)
    else $error("packet exceeds size cap");
  a_copy_init: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) tx_start_out && is_multi |-> tx_pkt_out.init)
    else $error("multi copy without initializer");
  a_rx_closed: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) is_multi && st_r == TX_BUSY && !pkt_r.repeat_copy
    |-> !rx_enable_out)
    else $error("receiver open between copies");
  a_copy_back: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) tx_done_in && st_r == TX_BUSY && copies_r != 4'h0
    |=> tx_start_out && $stable(tx_pkt_out.len))
    else $error("copy not sent back to back");
  a_stream_noinit: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) tx_start_out && in_event_r && !is_multi &&
    !tx_pkt_out.repeat_copy && $past(in_event_r) |-> !tx_pkt_out.init)
    else $error("follow-on stream packet has initializer");
  a_end_holdoff: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) st_r == TX_GAP && !pkt_r.repeat_copy && !is_multi &&
    sent_r < cfg_in.streaming_limit && tx_level_in == '0 &&
    cfg_in.delay_slot_count != 8'h00
    |=> hold_slots_r >= cfg_in.delay_slot_count)
    else $error("stream end holdoff not loaded");
  a_limit_backoff: assert property (@(posedge ref_clk_in) disable iff
    (!rst_n_in) st_r == TX_GAP && !pkt_r.repeat_copy &&
    sent_r >= cfg_in.streaming_limit
    |=> hold_slots_r != 8'h00 && !in_event_r)
    else $error("limit reached without backoff");

endmodule : brls_scheduler

// >>> rtl/brls_pkg.sv
// shared constants and carriers of the basic rf link scheduler
package brls_pkg;

  localparam int CNT_W     = 16;
  localparam int ADDR_W    = 16;
  localparam int TAG_W     = 16;
  localparam int TAG_DEPTH = 4;

  localparam logic [ADDR_W-1:0] GLOBAL_ADDR = 16'hFFFF;

  // rf_mode_select encodings
  localparam logic [2:0] MODE_STREAM = 3'h0;
  localparam logic [2:0] MODE_MULTI  = 3'h1;
  localparam logic [2:0] MODE_REPEAT = 3'h5;
  localparam logic [2:0] MODE_DEST   = 3'h6;

  // timing: figures in ns, counts derived at 250 MHz
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SLOT_TIME_NS   = 1000;
  localparam int BYTE_TIME_NS   = 1000;
  localparam int LISTEN_TIME_NS = 20000;
  localparam int SLOT_CYCLES    = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam int BYTE_CYCLES    = BYTE_TIME_NS / CLK_PERIOD_NS;
  localparam int LISTEN_CYCLES  = LISTEN_TIME_NS / CLK_PERIOD_NS;

  localparam logic [15:0] LFSR_TAPS  = 16'hB400;
  localparam logic [15:0] LFSR_RESET = 16'hACE1;

  typedef struct packed {
    logic [2:0]        mode;
    logic [3:0]        retry_count;
    logic [CNT_W-1:0]  packetization_threshold;
    logic [CNT_W-1:0]  packetization_timeout;
    logic [CNT_W-1:0]  streaming_limit;
    logic [CNT_W-1:0]  max_packet_size;
    logic [7:0]        delay_slot_count;
    logic [3:0]        extra_transmit_count;
    logic              forced_sync;
    logic [ADDR_W-1:0] dest_address;
    logic [ADDR_W-1:0] address_mask;
    logic [ADDR_W-1:0] source_address;
  } brls_cfg_type;

  typedef struct packed {
    logic [ADDR_W-1:0] dest_address;
    logic [TAG_W-1:0]  packet_tag;
    logic [CNT_W-1:0]  len;
    logic              multi;
    logic              stream_end;
    logic              follow_on;
    logic [CNT_W-1:0]  remain_cyc;
  } brls_hdr_type;

  typedef struct packed {
    logic [CNT_W-1:0]  len;
    logic [ADDR_W-1:0] dest_address;
    logic [TAG_W-1:0]  packet_tag;
    logic              init;
    logic              repeat_copy;
  } brls_pkt_type;

endpackage : brls_pkg

// >>> rtl/brls_tag_record.sv
// four-entry fifo record of recently seen packet tags
`timescale 1ns/1ps
module brls_tag_record #(
  parameter int DEPTH = brls_pkg::TAG_DEPTH,
  parameter int W     = brls_pkg::TAG_W
) (
  // clock and reset
  input  wire logic         ref_clk_in,
  input  wire logic         rst_n_in,
  // lookup, answer one cycle later from a register
  input  wire logic         look_in,
  input  wire logic [W-1:0] look_tag_in,
  output logic              hit_out,
  // insert at the fifo head, oldest entry falls out
  input  wire logic         ins_in,
  input  wire logic [W-1:0] ins_tag_in
);

  logic [W-1:0] tag_r   [DEPTH];
  logic [W-1:0] tag_nxt [DEPTH];
  logic [DEPTH-1:0] vld_r, vld_nxt;
  logic hit_r, hit_nxt;

  always_comb begin
    hit_nxt = 1'b0;
    vld_nxt = vld_r;
    for (int i = 0; i < DEPTH; i++) begin
      tag_nxt[i] = tag_r[i];
      if (look_in && vld_r[i] && tag_r[i] == look_tag_in) begin
        hit_nxt = 1'b1;
      end
    end
    if (ins_in) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        tag_nxt[i] = tag_r[i-1];
      end
      tag_nxt[0] = ins_tag_in;
      vld_nxt    = {vld_r[DEPTH-2:0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vld_r <= '0;
      hit_r <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        tag_r[i] <= '0;
      end
    end else begin
      vld_r <= vld_nxt;
      hit_r <= hit_nxt;
      for (int i = 0; i < DEPTH; i++) begin
        tag_r[i] <= tag_nxt[i];
      end
    end
  end

  assign hit_out = hit_r;

endmodule : brls_tag_record

// >>> test/brls_radio_model.sv
// radio and host transmit buffer stand-in on the scheduler's far side
`timescale 1ns/1ps
module brls_radio_model #(
  parameter int DONE_LAT = 6
) (
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_n_in,
  // scheduler transmit side
  input  wire brls_pkg::brls_pkt_type     tx_pkt_in,
  input  wire logic                       tx_start_in,
  output logic                            tx_done_out,
  // host buffer level
  input  wire logic                       load_in,
  input  wire logic [brls_pkg::CNT_W-1:0] load_val_in,
  output logic [brls_pkg::CNT_W-1:0]      level_out
);
  int   busy_r;
  logic done_d_r;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r      <= 0;
      tx_done_out <= 1'b0;
      done_d_r    <= 1'b0;
      level_out   <= '0;
    end else begin
      done_d_r    <= tx_done_out;
      tx_done_out <= (busy_r == 1);
      // one packet on air at a time
      if (tx_start_in) begin
        busy_r <= DONE_LAT;
      end else if (busy_r > 0) begin
        busy_r <= busy_r - 1;
      end
      // copies and repeats leave the host buffer alone
      if (load_in) begin
        level_out <= load_val_in;
      end else if (tx_start_in && !done_d_r && !tx_pkt_in.repeat_copy
                   && tx_pkt_in.len <= level_out) begin
        level_out <= level_out - tx_pkt_in.len;
      end
    end
  end
endmodule : brls_radio_model

// >>> test/brls_scheduler_tb.sv
// self-checking bench of the rf link scheduler
`timescale 1ns/1ps
module brls_scheduler_tb;
  logic                       ref_clk_in = 1'b0;
  logic                       rst_n_in   = 1'b0;
  brls_pkg::brls_cfg_type     cfg        = '0;
  brls_pkg::brls_hdr_type     hdr        = '0;
  brls_pkg::brls_pkt_type     pkt;
  logic                       rx_valid   = 1'b0;
  logic                       load       = 1'b0;
  logic [brls_pkg::CNT_W-1:0] load_val   = '0;
  logic [brls_pkg::CNT_W-1:0] level;
  logic start, done, rx_en, deliver, drop, retune, listen, hold, cfg_err;
  int   err_total = 0;
  int   n_checks  = 0;

  always #2 ref_clk_in = ~ref_clk_in;

  // short slots keep the run brief
  brls_scheduler #(.SLOT_CYC(4), .BYTE_CYC(4), .LISTEN_CYC(20))
    brls_scheduler_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .cfg_in(cfg), .seed_in(16'h1234), .tx_level_in(level),
    .tx_pkt_out(pkt), .tx_start_out(start), .tx_done_in(done),
    .rx_valid_in(rx_valid), .rx_hdr_in(hdr), .rx_enable_out(rx_en),
    .deliver_out(deliver), .drop_out(drop), .retune_out(retune),
    .listen_out(listen), .tx_holdoff_out(hold), .cfg_err_out(cfg_err));
  brls_radio_model brls_radio_model_i (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .tx_pkt_in(pkt), .tx_start_in(start),
    .tx_done_out(done), .load_in(load), .load_val_in(load_val),
    .level_out(level));

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // header pulse; the answer pulse stands one edge after it is taken
  task automatic rx_one(input logic [15:0] dest, input logic [15:0] tag,
                        output logic del, output logic drp);
    @(posedge ref_clk_in);
    rx_valid <= 1'b1;
    hdr      <= '{dest_address: dest, packet_tag: tag, len: 16'h0004,
                  default: '0};
    @(posedge ref_clk_in);
    rx_valid <= 1'b0;
    hdr      <= ~hdr;
    @(posedge ref_clk_in);
    #1;
    del = deliver;
    drp = drop;
  endtask : rx_one

  task automatic load_lvl(input logic [15:0] v);
    @(posedge ref_clk_in);
    load     <= 1'b1;
    load_val <= v;
    @(posedge ref_clk_in);
    load     <= 1'b0;
  endtask : load_lvl

  // counts starts over a fixed window, init bits newest in bit 0
  task automatic count_tx(input int cyc, output int n, output logic [7:0] ini,
                          output logic rx_low, output logic held);
    n = 0;
    ini = '0;
    rx_low = 1'b0;
    held = 1'b0;
    repeat (cyc) begin
      @(posedge ref_clk_in);
      #1;
      if (start === 1'b1) begin
        n++;
        ini = {ini[6:0], pkt.init};
      end
      if (rx_en !== 1'b1) rx_low = 1'b1;
      if (hold === 1'b1) held = 1'b1;
    end
  endtask : count_tx

  ////////////////////////////////////////////////////////////////////////////
  task automatic sc_receive;
    logic d, p;
    @(posedge ref_clk_in);
    cfg.mode <= brls_pkg::MODE_DEST;
    rx_one(16'hFFFF, 16'h0001, d, p);
    chk("global deliver", 1, {d, p} == 2'b10);
    rx_one(16'h0012, 16'h0002, d, p);
    chk("local deliver", 1, {d, p} == 2'b10);
    rx_one(16'h0034, 16'h0003, d, p);
    chk("mismatch drop", 1, {d, p} == 2'b01);
    rx_one(16'hFFFF, 16'h0001, d, p);
    chk("seen tag ignored", 1, {d, p} == 2'b00);
    for (int t = 4; t < 8; t++) rx_one(16'hFFFF, 16'(t), d, p);
    rx_one(16'hFFFF, 16'h0001, d, p);
    chk("evicted tag", 1, {d, p} == 2'b10);
  endtask : sc_receive

  task automatic sc_repeat;
    logic d, p, rl, hd;
    logic [7:0] ini;
    int n;
    @(posedge ref_clk_in);
    cfg.mode <= brls_pkg::MODE_REPEAT;
    rx_one(16'hFFFF, 16'h0009, d, p);
    count_tx(40, n, ini, rl, hd);
    chk("repeat deliver", 1, d);
    chk("repeat count", 1, 16'(n));
    chk("repeat flag", 1, pkt.repeat_copy);
    rx_one(16'hFFFF, 16'h0009, d, p);
    count_tx(40, n, ini, rl, hd);
    chk("no second repeat", 0, 16'(n));
  endtask : sc_repeat

  task automatic sc_multi;
    logic rl, hd;
    logic [7:0] ini;
    int n;
    @(posedge ref_clk_in);
    cfg.mode                 <= brls_pkg::MODE_MULTI;
    cfg.extra_transmit_count <= 4'h2;
    cfg.forced_sync          <= 1'b1;
    // three copies would reach this limit, one packet does not
    cfg.streaming_limit      <= 16'h000B;
    load_lvl(16'h000A);
    count_tx(120, n, ini, rl, hd);
    chk("copy count", 3, 16'(n));
    chk("limit once", 0, hd);
    chk("copy init", 16'h0007, 16'(ini));
    chk("rx off", 1, rl);
    chk("level", 0, level);
  endtask : sc_multi

  task automatic sc_stream;
    logic rl, hd;
    logic [7:0] ini;
    int n;
    @(posedge ref_clk_in);
    cfg.mode                    <= brls_pkg::MODE_STREAM;
    cfg.max_packet_size         <= 16'h0004;
    cfg.packetization_threshold <= 16'h0008;
    cfg.delay_slot_count        <= 8'h02;
    load_lvl(16'h0008);
    count_tx(80, n, ini, rl, hd);
    chk("stream count", 2, 16'(n));
    chk("stream end holdoff", 1, hd);
    chk("stream init", 16'h0002, 16'(ini));
  endtask : sc_stream

  task automatic sc_cfg_err;
    logic rl, hd;
    logic [7:0] ini;
    int n;
    @(posedge ref_clk_in);
    cfg.retry_count <= 4'h1;
    load_lvl(16'h0008);
    count_tx(40, n, ini, rl, hd);
    chk("cfg error", 1, cfg_err);
    chk("blocked tx", 0, 16'(n));
    load_lvl(16'h0000);
    cfg.retry_count <= 4'h0;
  endtask : sc_cfg_err

  task automatic sc_limit;
    logic rl, hd;
    logic [7:0] ini;
    int n;
    @(posedge ref_clk_in);
    cfg.streaming_limit  <= 16'h0004;
    cfg.delay_slot_count <= 8'h03;
    load_lvl(16'h0008);
    count_tx(40, n, ini, rl, hd);
    chk("limit count", 1, 16'(n));
    chk("back-off seen", 1, hd);
  endtask : sc_limit

  task automatic sc_follow;
    @(posedge ref_clk_in);
    rx_valid <= 1'b1;
    hdr      <= '{dest_address: 16'hFFFF, packet_tag: 16'h0020,
                  multi: 1'b1, follow_on: 1'b1, remain_cyc: 16'h0008,
                  default: '0};
    @(posedge ref_clk_in);
    rx_valid <= 1'b0;
    @(posedge ref_clk_in);
    #1;
    chk("retune pulse", 1, retune);
    chk("listen window", 1, listen);
    chk("multi rx holdoff", 1, hold);
    // listen lasts 20 cycles, hold-off 8 cycles plus at most 2 slots
    repeat (25) @(posedge ref_clk_in);
    #1;
    chk("listen ends", 0, listen);
    chk("holdoff ends", 0, hold);
  endtask : sc_follow

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_total++;
    stop_test();
  end

  initial begin
    cfg.address_mask            = 16'hFFFF;
    cfg.source_address          = 16'h0012;
    cfg.dest_address            = 16'hFFFF;
    cfg.streaming_limit         = 16'hFFFF;
    cfg.max_packet_size         = 16'h0010;
    cfg.packetization_threshold = 16'h0001;
    cfg.packetization_timeout   = 16'hFFFF;
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sc_receive();
    sc_repeat();
    sc_multi();
    sc_stream();
    sc_cfg_err();
    sc_limit();
    sc_follow();
    stop_test();
  end
endmodule : brls_scheduler_tb
